// ==== verilog/peripheral_irq_flag_priority.sv ====
`timescale 1ns/1ps
`default_nettype none
module peripheral_irq_flag_priority #(
  parameter int HOST_PORT_PRESENT = 1
) (
  input  wire logic        mclk_i,             // Core clock, 40 MHz.
  input  wire logic        rst_i,              // Synchronous reset, active high.
  input  wire logic        hsel_i,             // AHB slave select.
  input  wire logic [31:0] haddr_i,            // AHB address.
  input  wire logic [1:0]  htrans_i,           // AHB transfer type.
  input  wire logic        hwrite_i,           // AHB write.
  input  wire logic [2:0]  hsize_i,            // AHB size.
  input  wire logic [31:0] hwdata_i,           // AHB write data.
  input  wire logic        hready_i,           // AHB ready.
  output logic [31:0]      hrdata_o,           // AHB read data.
  output logic             hreadyout_o,        // AHB slave ready.
  output logic             hresp_o,            // AHB response.
  input  wire logic        host_port_access_i, // Pulse: host port read or write.
  input  wire logic        converter_done_i,   // Pulse: conversion finished.
  input  wire logic        receive_full_i,     // Level: receive buffer full.
  input  wire logic        transmit_empty_i,   // Level: transmit buffer empty.
  input  wire logic        sync_serial_done_i, // Pulse: serial transfer done.
  input  wire logic        capture_evt_i,      // Pulse: timer 1 capture.
  input  wire logic        compare_evt_i,      // Pulse: timer 1 compare match.
  input  wire logic [1:0]  ccp_mode_i,         // Capture/compare unit mode.
  input  wire logic        timer2_match_i,     // Pulse: timer 2 equals period.
  input  wire logic        timer1_ovf_i,       // Pulse: timer 1 overflow.
  output logic             high_req_o,         // High-priority request.
  output logic             low_req_o           // Low-priority request.
);

  // ---------------------------------------------------------------------------
  // Parameter check
  // ---------------------------------------------------------------------------

  // Only present (1) or absent (0) is meaningful for the host port.
  // The small package has no host port;
  // its flag then always reads zero.
  if (HOST_PORT_PRESENT != 0 && HOST_PORT_PRESENT != 1) begin : g_bad_param
    $error("HOST_PORT_PRESENT must be 0 or 1");
  end

  // ---------------------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------------------

  // Matches an access offset against a register offset.
  // Only address bits 7:0 are decoded, so
  // the register window repeats upward,
  // and the size field is not checked.
  function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] ofs);
    reg_hit = (addr == ofs);
  endfunction : reg_hit

  // ---------------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------------

  // Each _q is a flop, each _d its next value.
  irq_pkg::reg_access_t acc;
  irq_pkg::irq_cfg_t    cfg;
  logic [31:0]          rdata;
  logic [7:0]           flag_q,   flag_d;
  logic [7:0]           prio_q,   prio_d;
  logic [7:0]           enable_q, enable_d;
  logic                 prio_en_q, prio_en_d;
  logic                 low_en_q,  low_en_d;
  logic                 high_en_q, high_en_d;
  logic [7:0]           set_evt;
  logic [7:0]           sticky_wr;
  logic [7:0]           impl_mask;
  logic                 capcmp_evt;
  logic                 high_req, low_req;

  // ---------------------------------------------------------------------------
  // Bus slave
  // ---------------------------------------------------------------------------

  // The bus front end turns AHB-Lite phases into register strobes.
  // Writes take no wait state; reads take one,
  // giving the read multiplexer a full cycle.
  ahb_reg_port u_port (
    .mclk_i      (mclk_i),
    .rst_i       (rst_i),
    .hsel_i      (hsel_i),
    .haddr_i     (haddr_i),
    .htrans_i    (htrans_i),
    .hwrite_i    (hwrite_i),
    .hsize_i     (hsize_i),
    .hwdata_i    (hwdata_i),
    .hready_i    (hready_i),
    .rdata_i     (rdata),
    .access_o    (acc),
    .hrdata_o    (hrdata_o),
    .hreadyout_o (hreadyout_o),
    .hresp_o     (hresp_o)
  );

  // ---------------------------------------------------------------------------
  // Source events
  // ---------------------------------------------------------------------------

  // The capture/compare source counts only in the matching mode.
  // Waveform mode and the spare code drop
  // any event pulse.
  always_comb begin
    case (irq_pkg::ccp_mode_t'(ccp_mode_i))
      irq_pkg::CCP_CAPTURE:  capcmp_evt = capture_evt_i;
      irq_pkg::CCP_COMPARE:  capcmp_evt = compare_evt_i;
      irq_pkg::CCP_WAVEFORM: capcmp_evt = 1'b0;
      default:               capcmp_evt = 1'b0;
    endcase
  end

  // Gather set events; no enable of any kind gates them.
  // Bits 5 and 4 are levels, not events,
  // and are handled apart below.
  always_comb begin
    set_evt                         = 8'h00;
    set_evt[irq_pkg::BIT_HOST_PORT] = host_port_access_i;
    set_evt[irq_pkg::BIT_CONVERTER] = converter_done_i;
    set_evt[irq_pkg::BIT_SYNC]      = sync_serial_done_i;
    set_evt[irq_pkg::BIT_CAPCMP]    = capcmp_evt;
    set_evt[irq_pkg::BIT_TIMER2]    = timer2_match_i;
    set_evt[irq_pkg::BIT_TIMER1]    = timer1_ovf_i;
  end

  // Bits that exist in this build; the host port bit is gone without the port.
  // Masking next value and read path keeps
  // a missing bit at zero.
  always_comb begin
    impl_mask                         = 8'hff;
    impl_mask[irq_pkg::BIT_HOST_PORT] = (HOST_PORT_PRESENT == 1);
  end

  // Software write data for the flag register.
  assign sticky_wr = acc.wdata[7:0];

  // ---------------------------------------------------------------------------
  // Request flags
  // ---------------------------------------------------------------------------

  // Sticky flags: a write stores the bit, an event in the same cycle wins.
  // So a clear never hides an event that
  // software has not yet seen; software
  // clears a flag before enabling it and
  // again after servicing it.
  for (genvar i = 0; i < 8; i++) begin : g_flag
    if (irq_pkg::STICKY_MASK[i]) begin : g_sticky
      always_comb begin
        if (acc.wr && reg_hit(acc.addr, irq_pkg::OFS_FLAGS)) begin
          flag_d[i] = (sticky_wr[i] | set_evt[i]) & impl_mask[i];
        end else begin
          flag_d[i] = (flag_q[i] | set_evt[i]) & impl_mask[i];
        end
      end
    end else begin : g_level
      // Buffer-state flags track their source and ignore writes.
      // The serial unit drops the level when
      // its buffer is read or written.
      always_comb begin
        if (i == irq_pkg::BIT_RECEIVE) begin
          flag_d[i] = receive_full_i;
        end else begin
          flag_d[i] = transmit_empty_i;
        end
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Priority, enable and control registers
  // ---------------------------------------------------------------------------

  // Software-written configuration registers.
  // Only write data bits 7:0 matter; control
  // keeps just its three defined bits.
  always_comb begin
    prio_d    = prio_q;
    enable_d  = enable_q;
    prio_en_d = prio_en_q;
    low_en_d  = low_en_q;
    high_en_d = high_en_q;
    if (acc.wr) begin
      if (reg_hit(acc.addr, irq_pkg::OFS_PRIO)) begin
        prio_d = acc.wdata[7:0];
      end
      if (reg_hit(acc.addr, irq_pkg::OFS_ENABLE)) begin
        enable_d = acc.wdata[7:0];
      end
      if (reg_hit(acc.addr, irq_pkg::OFS_CTRL)) begin
        prio_en_d = acc.wdata[irq_pkg::CTRL_PRIO_EN_BIT];
        low_en_d  = acc.wdata[irq_pkg::CTRL_LOW_EN_BIT];
        high_en_d = acc.wdata[irq_pkg::CTRL_HIGH_EN_BIT];
      end
    end
  end

  // Register all software-visible state.
  // Reset sets all priorities high and all
  // enables low: no request until set up.
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      flag_q    <= irq_pkg::RST_FLAGS;
      prio_q    <= irq_pkg::RST_PRIO;
      enable_q  <= irq_pkg::RST_ENABLE;
      prio_en_q <= 1'b0;
      low_en_q  <= 1'b0;
      high_en_q <= 1'b0;
    end else begin
      flag_q    <= flag_d;
      prio_q    <= prio_d;
      enable_q  <= enable_d;
      prio_en_q <= prio_en_d;
      low_en_q  <= low_en_d;
      high_en_q <= high_en_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------------------

  // Read multiplexer; unmapped offsets read as zero.
  // Active only in the read wait cycle; the
  // bus front end registers its result.
  // Status shows the registered requests.
  always_comb begin
    rdata = irq_pkg::RDATA_NONE;
    if (acc.rd) begin
      if (reg_hit(acc.addr, irq_pkg::OFS_FLAGS)) begin
        rdata[7:0] = flag_q & impl_mask;
      end
      if (reg_hit(acc.addr, irq_pkg::OFS_PRIO)) begin
        rdata[7:0] = prio_q;
      end
      if (reg_hit(acc.addr, irq_pkg::OFS_ENABLE)) begin
        rdata[7:0] = enable_q;
      end
      if (reg_hit(acc.addr, irq_pkg::OFS_CTRL)) begin
        rdata[irq_pkg::CTRL_PRIO_EN_BIT] = prio_en_q;
        rdata[irq_pkg::CTRL_LOW_EN_BIT]  = low_en_q;
        rdata[irq_pkg::CTRL_HIGH_EN_BIT] = high_en_q;
      end
      if (reg_hit(acc.addr, irq_pkg::OFS_STATUS)) begin
        rdata[irq_pkg::STAT_HIGH_BIT] = high_req;
        rdata[irq_pkg::STAT_LOW_BIT]  = low_req;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Request outputs
  // ---------------------------------------------------------------------------

  // Enables steer the requests; they never gate the flags themselves.
  // With priority, the enables gate the two
  // levels; without it, both must be set and
  // the one request uses the high line.
  assign cfg.prio_en = prio_en_q;
  assign cfg.low_en  = low_en_q;
  assign cfg.high_en = high_en_q;

  // Priority resolution into the two request lines.
  // Registered inside, so both outputs come
  // from flops, one edge after a flag.
  irq_priority_resolve #(
    .N (8)
  ) u_resolve (
    .mclk_i     (mclk_i),
    .rst_i      (rst_i),
    .pending_i  (flag_q & enable_q & impl_mask),
    .prio_i     (prio_q),
    .cfg_i      (cfg),
    .high_req_o (high_req),
    .low_req_o  (low_req)
  );

  // Requests to the core's vectoring logic.
  assign high_req_o = high_req;
  assign low_req_o  = low_req;

endmodule : peripheral_irq_flag_priority
`default_nettype wire

// ==== verilog/irq_pkg.sv ====
package irq_pkg;

  // ---------------------------------------------------------------------------
  // Register map (byte offsets within the slave window)
  // ---------------------------------------------------------------------------
  localparam logic [7:0] OFS_FLAGS  = 8'h00; // Peripheral request flags 1.
  localparam logic [7:0] OFS_PRIO   = 8'h04; // Peripheral request priority 1.
  localparam logic [7:0] OFS_ENABLE = 8'h08; // Per-source enables.
  localparam logic [7:0] OFS_CTRL   = 8'h0c; // Interrupt control bits.
  localparam logic [7:0] OFS_STATUS = 8'h10; // Request output status.

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int BIT_HOST_PORT = 7;
  localparam int BIT_CONVERTER = 6;
  localparam int BIT_RECEIVE   = 5;
  localparam int BIT_TRANSMIT  = 4;
  localparam int BIT_SYNC      = 3;
  localparam int BIT_CAPCMP    = 2;
  localparam int BIT_TIMER2    = 1;
  localparam int BIT_TIMER1    = 0;

  localparam int CTRL_PRIO_EN_BIT = 0; // Priority enable.
  localparam int CTRL_LOW_EN_BIT  = 6; // Peripheral / low-priority enable.
  localparam int CTRL_HIGH_EN_BIT = 7; // Global / high-priority enable.

  localparam int STAT_HIGH_BIT = 0;
  localparam int STAT_LOW_BIT  = 1;

  // ---------------------------------------------------------------------------
  // Reset values and masks
  // ---------------------------------------------------------------------------
  localparam logic [7:0]  RST_FLAGS   = 8'h00;
  localparam logic [7:0]  RST_PRIO    = 8'hff;
  localparam logic [7:0]  RST_ENABLE  = 8'h00;
  localparam logic [7:0]  STICKY_MASK = 8'hcf; // Flags that software clears.
  localparam logic [31:0] RDATA_NONE  = 32'h0000_0000;

  // ---------------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    CCP_CAPTURE  = 2'b00,
    CCP_COMPARE  = 2'b01,
    CCP_WAVEFORM = 2'b10
  } ccp_mode_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_WRITE = 2'b01,
    ST_READ  = 2'b10
  } bus_state_t;

  typedef struct packed {
    logic        wr;    // Write strobe in the data phase.
    logic        rd;    // Read strobe in the data phase.
    logic [7:0]  addr;  // Byte offset of the access.
    logic [31:0] wdata; // Write data.
  } reg_access_t;

  typedef struct packed {
    logic prio_en;
    logic low_en;
    logic high_en;
  } irq_cfg_t;

endpackage : irq_pkg

// ==== verilog/ahb_reg_port.sv ====
`timescale 1ns/1ps
`default_nettype none
module ahb_reg_port (
  input  wire logic                 mclk_i,      // Core clock.
  input  wire logic                 rst_i,       // Synchronous reset.
  input  wire logic                 hsel_i,      // Slave select.
  input  wire logic [31:0]          haddr_i,     // Address.
  input  wire logic [1:0]           htrans_i,    // Transfer type.
  input  wire logic                 hwrite_i,    // Write direction.
  input  wire logic [2:0]           hsize_i,     // Transfer size.
  input  wire logic [31:0]          hwdata_i,    // Write data.
  input  wire logic                 hready_i,    // Bus ready.
  input  wire logic [31:0]          rdata_i,     // Read data from registers.
  output irq_pkg::reg_access_t      access_o,    // Register access strobes.
  output logic [31:0]               hrdata_o,    // Read data.
  output logic                      hreadyout_o, // Slave ready.
  output logic                      hresp_o      // Response, always OKAY.
);

  irq_pkg::bus_state_t state_q, state_d;
  logic [7:0]          addr_q, addr_d;
  logic [31:0]         hrdata_q, hrdata_d;
  logic                rdy_q, rdy_d;
  logic                take;

  // Only word transfers are used; size is accepted as a whole word.
  assign take = hsel_i & htrans_i[1] & hready_i & (state_q != irq_pkg::ST_READ);

  // Next state: writes finish with no wait, reads insert one wait state.
  always_comb begin
    state_d  = irq_pkg::ST_IDLE;
    addr_d   = addr_q;
    hrdata_d = hrdata_q;
    if (state_q == irq_pkg::ST_READ) begin
      hrdata_d = rdata_i;
    end
    if (take) begin
      addr_d  = haddr_i[7:0];
      state_d = hwrite_i ? irq_pkg::ST_WRITE : irq_pkg::ST_READ;
    end
    rdy_d = (state_d != irq_pkg::ST_READ);
  end

  // State registers.
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      state_q  <= irq_pkg::ST_IDLE;
      addr_q   <= 8'h00;
      hrdata_q <= irq_pkg::RDATA_NONE;
      rdy_q    <= 1'b1;
      hresp_o  <= 1'b0;
    end else begin
      state_q  <= state_d;
      addr_q   <= addr_d;
      hrdata_q <= hrdata_d;
      rdy_q    <= rdy_d;
      hresp_o  <= 1'b0;
    end
  end

  // Strobes to the register file and bus outputs.
  assign access_o.wr    = (state_q == irq_pkg::ST_WRITE);
  assign access_o.rd    = (state_q == irq_pkg::ST_READ);
  assign access_o.addr  = addr_q;
  assign access_o.wdata = hwdata_i;
  assign hrdata_o       = hrdata_q;
  assign hreadyout_o    = rdy_q;

endmodule : ahb_reg_port
`default_nettype wire

// ==== verilog/irq_priority_resolve.sv ====
`timescale 1ns/1ps
`default_nettype none
module irq_priority_resolve #(
  parameter int N = 8
) (
  input  wire logic              mclk_i,     // Core clock.
  input  wire logic              rst_i,      // Synchronous reset.
  input  wire logic [N-1:0]      pending_i,  // Set and enabled flags.
  input  wire logic [N-1:0]      prio_i,     // 1 high, 0 low.
  input  wire irq_pkg::irq_cfg_t cfg_i,      // Global enables.
  output logic                   high_req_o, // High-priority request.
  output logic                   low_req_o   // Low-priority request.
);

  // At least one source is needed.
  if (N < 1) begin : g_bad_n
    $error("N must be at least 1");
  end

  logic high_d, low_d;

  // Split pending sources by priority, or merge them into one level.
  always_comb begin
    if (cfg_i.prio_en) begin
      high_d = cfg_i.high_en & |(pending_i & prio_i);
      low_d  = cfg_i.high_en & cfg_i.low_en & |(pending_i & ~prio_i);
    end else begin
      high_d = cfg_i.high_en & cfg_i.low_en & |pending_i;
      low_d  = 1'b0;
    end
  end

  // Request registers.
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      high_req_o <= 1'b0;
      low_req_o  <= 1'b0;
    end else begin
      high_req_o <= high_d;
      low_req_o  <= low_d;
    end
  end

endmodule : irq_priority_resolve
`default_nettype wire

// ==== verification/irq_flag_checker_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// Bus timing and request gating checks
// ---------------------------------------------------------------
module irq_flag_checker (
  input wire logic        mclk_i,       // Core clock.
  input wire logic        rst_i,        // Synchronous reset.
  input wire logic        hsel_i,       // Slave select.
  input wire logic [31:0] haddr_i,      // Address.
  input wire logic [1:0]  htrans_i,     // Transfer type.
  input wire logic        hwrite_i,     // Write.
  input wire logic [31:0] hwdata_i,     // Write data.
  input wire logic        hready_i,     // Bus ready.
  input wire logic [31:0] hrdata_o,     // Read data.
  input wire logic        hreadyout_o,  // Slave ready.
  input wire logic        timer1_ovf_i, // Timer 1 overflow.
  input wire logic        high_req_o,   // High request.
  input wire logic        low_req_o     // Low request.
);
  logic [7:0] pr_q;
  logic [7:0] en_q;
  logic [7:0] ct_q;
  logic [7:0] wa_q;
  logic       wv_q;
  logic       pe;
  logic       le;
  logic       he;
  logic       hc;

  // Shadow copy of the configuration, snooped from completed writes.
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      pr_q <= irq_pkg::RST_PRIO;
      en_q <= irq_pkg::RST_ENABLE;
      ct_q <= 8'h00;
      wv_q <= 1'b0;
      wa_q <= 8'h00;
    end else begin
      wv_q <= hsel_i && htrans_i[1] && hready_i && hwrite_i;
      wa_q <= haddr_i[7:0];
      if (wv_q && wa_q == irq_pkg::OFS_PRIO) begin
        pr_q <= hwdata_i[7:0];
      end
      if (wv_q && wa_q == irq_pkg::OFS_ENABLE) begin
        en_q <= hwdata_i[7:0];
      end
      if (wv_q && wa_q == irq_pkg::OFS_CTRL) begin
        ct_q <= hwdata_i[7:0];
      end
    end
  end

  // Decoded enables; hc means timer 1 is routed to the high level.
  assign pe = ct_q[irq_pkg::CTRL_PRIO_EN_BIT];
  assign le = ct_q[irq_pkg::CTRL_LOW_EN_BIT];
  assign he = ct_q[irq_pkg::CTRL_HIGH_EN_BIT];
  assign hc = pe && he && en_q[0] && pr_q[0];

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  chk_read_wait: assert property ((hsel_i && htrans_i[1] && hready_i && !hwrite_i)
    |=> !hreadyout_o ##1 hreadyout_o) else $error("read wait state wrong");
  chk_write_nowait: assert property ((hsel_i && htrans_i[1] && hready_i && hwrite_i)
    |=> hreadyout_o) else $error("write stalled");
  chk_read_upper: assert property ($rose(hreadyout_o) |-> hrdata_o[31:8] == 24'h0)
    else $error("upper read bits not zero");
  chk_single_level: assert property (!pe [*3] |-> !low_req_o)
    else $error("low request without priority");
  chk_global_off: assert property (!he [*3] |-> !high_req_o && !low_req_o)
    else $error("request with global enable off");
  chk_both_needed: assert property ((!pe && !le) [*3] |-> !high_req_o)
    else $error("request without peripheral enable");
  chk_all_high: assert property ((pe && pr_q == 8'hff) [*3] |-> !low_req_o)
    else $error("low request with all sources high");
  chk_all_low: assert property ((pe && pr_q == 8'h00) [*3] |-> !high_req_o)
    else $error("high request with all sources low");
  chk_ovf_request: assert property (hc [*3] ##0 timer1_ovf_i |-> ##[1:3] high_req_o)
    else $error("overflow gave no high request");

  cover property (high_req_o);
  cover property (low_req_o);
  cover property (!hreadyout_o);
endmodule : irq_flag_checker

bind peripheral_irq_flag_priority irq_flag_checker i_chk (.*);
`default_nettype wire

// ==== verification/irq_core_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// Core side: the level the core would vector to
// ---------------------------------------------------------------
module irq_core_model (
  input  wire logic       mclk_i,     // Core clock.
  input  wire logic       rst_i,      // Synchronous reset.
  input  wire logic       high_req_i, // High request from the block.
  input  wire logic       low_req_i,  // Low request from the block.
  output logic      [1:0] level_o     // 2 high, 1 low, 0 none.
);
  // High requests pre-empt low ones when both stand.
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      level_o <= 2'h0;
    end else begin
      level_o <= high_req_i ? 2'h2 : (low_req_i ? 2'h1 : 2'h0);
    end
  end
endmodule : irq_core_model
`default_nettype wire

// ==== verification/peripheral_irq_flag_priority_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module peripheral_irq_flag_priority_bench;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic        mclk_i, rst_i, hsel_i, hwrite_i, receive_full_i, transmit_empty_i;
  logic [1:0]  htrans_i, ccp_mode_i, level;
  logic [2:0]  hsize_i;
  logic [7:0]  ev;
  logic [31:0] haddr_i, hwdata_i, hrdata_o, hrdata_s, rd, rds;
  logic        hreadyout_o, rdy_s, hresp_o, high_req_o, low_req_o;
  wire logic   hready_i = hreadyout_o;
  wire logic   host_port_access_i = ev[7];
  wire logic   converter_done_i = ev[6];
  wire logic   compare_evt_i = ev[4];
  wire logic   sync_serial_done_i = ev[3];
  wire logic   capture_evt_i = ev[2];
  wire logic   timer2_match_i = ev[1];
  wire logic   timer1_ovf_i = ev[0];
  int          errors, total_checks;

  peripheral_irq_flag_priority i_dut (.*);
  peripheral_irq_flag_priority #(.HOST_PORT_PRESENT(0)) i_small (.*,
    .hready_i(rdy_s), .hrdata_o(hrdata_s), .hreadyout_o(rdy_s),
    .hresp_o(), .high_req_o(), .low_req_o());
  irq_core_model i_core (.mclk_i(mclk_i), .rst_i(rst_i), .high_req_i(high_req_o),
    .low_req_i(low_req_o), .level_o(level));

  // Free-running core clock.
  initial begin
    mclk_i = 1'b0;
    forever #12.5 mclk_i = ~mclk_i;
  end

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // One single word transfer; both slaves answer with the same timing.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel_i <= 1'b1;
    htrans_i <= 2'b10;
    haddr_i <= {24'h0, a};
    hwrite_i <= w;
    do @(posedge mclk_i); while (!hreadyout_o);
    hsel_i <= 1'b0;
    htrans_i <= 2'b00;
    hwdata_i <= d;
    do @(posedge mclk_i); while (!hreadyout_o);
    rd = hrdata_o;
    rds = hrdata_s;
  endtask : bus

  // Reads a register; the variant without host port never shows flag bit 7.
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(nm, e, rd);
    chk("resp", 32'h0, {31'h0, hresp_o});
    if (a == irq_pkg::OFS_FLAGS) chk("small flags", e & 32'h7f, rds);
  endtask : rdc

  task automatic pulse(input logic [7:0] m);
    ev <= m;
    @(posedge mclk_i);
    ev <= 8'h00;
    @(posedge mclk_i);
  endtask : pulse

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    rdc("flags", irq_pkg::OFS_FLAGS, 32'h10);
    rdc("prio", irq_pkg::OFS_PRIO, 32'hff);
    rdc("enable", irq_pkg::OFS_ENABLE, 32'h0);
    rdc("ctrl", irq_pkg::OFS_CTRL, 32'h0);
    bus(1'b1, 8'h20, 32'hff);
    rdc("unmapped", 8'h20, 32'h0);
  endtask : t_reset

  // Every event source with all enables off; bit 4 of ev is compare.
  task automatic t_events;
    for (int i = 0; i < 8; i++) begin
      if (i == 5) continue;
      ccp_mode_i <= (i == 4) ? 2'b01 : 2'b00;
      pulse(8'h01 << i);
      rdc("flag set", irq_pkg::OFS_FLAGS, (i == 4) ? 32'h14 : (32'h10 | (32'h1 << i)));
      bus(1'b1, irq_pkg::OFS_FLAGS, 32'h0);
      rdc("flag clear", irq_pkg::OFS_FLAGS, 32'h10);
    end
    for (int m = 2; m < 4; m++) begin
      ccp_mode_i <= m[1:0];
      pulse(8'h14);
      rdc("ccp idle", irq_pkg::OFS_FLAGS, 32'h10);
    end
  endtask : t_events

  // Buffer-state flags follow their levels and ignore writes.
  task automatic t_levels;
    receive_full_i <= 1'b1;
    transmit_empty_i <= 1'b0;
    rdc("rx full", irq_pkg::OFS_FLAGS, 32'h20);
    bus(1'b1, irq_pkg::OFS_FLAGS, 32'hff);
    rdc("read only", irq_pkg::OFS_FLAGS, 32'hef);
    bus(1'b1, irq_pkg::OFS_FLAGS, 32'h0);
    receive_full_i <= 1'b0;
    transmit_empty_i <= 1'b1;
    rdc("tx empty", irq_pkg::OFS_FLAGS, 32'h10);
  endtask : t_levels

  // Timer 1 flag routed through six priority and enable settings.
  task automatic t_prio;
    logic [7:0] pv [6] = '{8'hff, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00};
    logic [7:0] cv [6] = '{8'h81, 8'h81, 8'hc1, 8'h41, 8'h80, 8'hc0};
    logic [1:0] ex [6] = '{2'b10, 2'b00, 2'b01, 2'b00, 2'b00, 2'b10};
    transmit_empty_i <= 1'b0;
    bus(1'b1, irq_pkg::OFS_FLAGS, 32'h0);
    bus(1'b1, irq_pkg::OFS_ENABLE, 32'h01);
    bus(1'b1, irq_pkg::OFS_PRIO, 32'h01);
    bus(1'b1, irq_pkg::OFS_CTRL, 32'h81);
    repeat (2) @(posedge mclk_i);
    pulse(8'h01);
    for (int k = 0; k < 6; k++) begin
      bus(1'b1, irq_pkg::OFS_PRIO, {24'h0, pv[k]});
      bus(1'b1, irq_pkg::OFS_CTRL, {24'h0, cv[k]});
      repeat (3) @(posedge mclk_i);
      chk("requests", {30'h0, ex[k]}, {30'h0, high_req_o, low_req_o});
      chk("core level", ex[k][1] ? 32'h2 : {31'h0, ex[k][0]}, {30'h0, level});
      rdc("status", irq_pkg::OFS_STATUS, {30'h0, ex[k][0], ex[k][1]});
    end
    bus(1'b1, irq_pkg::OFS_ENABLE, 32'h0);
    bus(1'b1, irq_pkg::OFS_FLAGS, 32'h0);
  endtask : t_prio

  // ---------------------------------------------------------------
  // Verdict, watchdog and main sequence
  // ---------------------------------------------------------------
  task automatic conclude;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : conclude

  // Cuts a hang short well beyond the expected run of about 190 cycles.
  initial begin
    #(5000 * 25);
    errors++;
    conclude();
  end

  initial begin
    errors = 0;
    total_checks = 0;
    rst_i = 1'b1;
    hsel_i = 1'b0;
    hwrite_i = 1'b0;
    htrans_i = 2'b00;
    hsize_i = 3'b010;
    haddr_i = 32'h0;
    hwdata_i = 32'h0;
    ev = 8'h00;
    ccp_mode_i = 2'b00;
    receive_full_i = 1'b0;
    transmit_empty_i = 1'b1;
    repeat (4) @(posedge mclk_i);
    rst_i <= 1'b0;
    @(posedge mclk_i);
    t_reset();
    t_events();
    t_levels();
    t_prio();
    conclude();
  end
endmodule : peripheral_irq_flag_priority_bench
`default_nettype wire
